// >>> rtl/ttr_defs.vh
// Register offsets, field positions and reset values for the dual timer.
// Assumes inclusion by the timer register block only.
`ifndef TTR_DEFS_VH
`define TTR_DEFS_VH
// ==========================================
// Register addresses, 8-bit internal I/O space
`define TTR_T1_CNT_L 8'h84
`define TTR_T1_CNT_H 8'h85
`define TTR_T1_CAP_L 8'h86
`define TTR_T1_CAP_H 8'h87
`define TTR_T1_CMPA_L 8'h88
`define TTR_T1_CMPA_H 8'h89
`define TTR_T1_CMPB_L 8'h8A
`define TTR_T1_CMPB_H 8'h8B
`define TTR_T1_CTRL_C 8'h82
`define TTR_T1_MODE 8'h81
`define TTR_T3_OFS 8'h10
`define TTR_T1_MASK 8'h6F
`define TTR_T3_MASK 8'h71
`define TTR_T1_FLAGS 8'h36
`define TTR_T3_FLAGS 8'h38
// ==========================================
// Bit positions in the mask and flag registers
`define TTR_BIT_CAP 5
`define TTR_BIT_MB 2
`define TTR_BIT_MA 1
`define TTR_BIT_OVF 0
`define TTR_USED_MASK 8'h27
// Force strobe positions in control register C
`define TTR_BIT_FOCA 7
`define TTR_BIT_FOCB 6
// ==========================================
// Reset values
`define TTR_RST_BYTE 8'h00
`define TTR_RST_WORD 16'h0000
`define TTR_MAX_WORD 16'hFFFF
`endif

// >>> rtl/ttr_timer_regs.v
// Two 16-bit timer register sets with shared high-byte latch, masks and event flags.
// Assumes a CPU core on the same clock, a timer-clock tick input and synchronous strobes.
//
// Overview of operation
// - Counter read and written as atomic byte pair
// - One high-byte latch shared by all words
// - Counter write blocks matches on next tick
// - Compare registers checked against counter continuously
// - Compare writes commit both bytes together
// - Capture event copies counter into capture register unless it serves as TOP
// - Capture read returns coherent 16-bit snapshot
// - Capture-as-TOP sets capture flag at TOP
// - Mask holds bits 5,2,1,0; others zero
// - Request needs enable, global enable and flag
// - Match flag set on tick after equality
// - Force strobe never sets match flag
// - Capture pin event sets capture flag unless capture register is TOP
// - Overflow flag set at overflow point
// - Vector entry clears its own flag
// - Writing one clears flag, zero keeps
// - Flag bits 5,2,1,0; others read zero
// - Force strobes non-PWM only, read zero
`timescale 1ns/1ps
`include "ttr_defs.vh"

module ttr_timer_regs #(
  parameter NTIM = 2
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // CPU internal I/O bus
  input wire [7:0] ioAddr,
  input wire [7:0] ioWdata,
  input wire ioWe,
  input wire ioRe,
  output reg [7:0] ioRdata,
  input wire globalIrqEnable,
  // Vector entry acknowledge, per timer: [4*t+3:4*t] = cap, mb, ma, ovf
  input wire [4*NTIM-1:0] vectorAck,
  // Timer domain hooks, per timer
  input wire [NTIM-1:0] timerTick,
  input wire [NTIM-1:0] captureEvent,
  input wire [16*NTIM-1:0] counterNext,
  input wire [4*NTIM-1:0] waveformModeBits,
  // Outputs
  output reg [4*NTIM-1:0] irqRequest,
  output reg [2*NTIM-1:0] matchPulse,
  output reg [2*NTIM-1:0] forcePulse,
  output reg [16*NTIM-1:0] counterValue,
  output reg [NTIM-1:0] counterWritten
);

  // ==========================================
  // Reset synchroniser
  // Assertion acts at once; release is retimed by two flip-flops so that
  // no register leaves reset on an edge where the pin is still settling.
  reg rstMeta_reg;
  reg rstSync_reg;
  wire rstN;
  // Shift a constant one through two stages
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  assign rstN = rstSync_reg;

  // ==========================================
  // Shared high-byte latch
  // Loaded by any high-byte write and by counter or capture low-byte reads;
  // interleaving two word accesses corrupts both, as software must avoid
  reg [7:0] tempHigh_reg; // Single latch for every 16-bit register
  reg [7:0] tempHigh_next;
  reg [7:0] rdata_next;

  // Per-timer state, flattened across timers
  // Timer t owns slice t of each vector
  reg [16*NTIM-1:0] cmpA_reg;
  reg [16*NTIM-1:0] cmpB_reg;
  reg [16*NTIM-1:0] cap_reg;
  reg [8*NTIM-1:0] mask_reg;
  reg [4*NTIM-1:0] flag_reg;
  reg [NTIM-1:0] block_reg; // Match blocking after a counter write

  // Per-timer decoded strobes, from the generate loop
  // One-hot per timer; no address hits two timers
  wire [NTIM-1:0] selCntL;
  wire [NTIM-1:0] selCntH;
  wire [NTIM-1:0] selCapL;
  wire [NTIM-1:0] selCapH;
  wire [NTIM-1:0] selCmpAL;
  wire [NTIM-1:0] selCmpAH;
  wire [NTIM-1:0] selCmpBL;
  wire [NTIM-1:0] selCmpBH;
  wire [NTIM-1:0] selMask;
  wire [NTIM-1:0] selFlags;
  wire [NTIM-1:0] selCtrlC;

  genvar t;
  generate
    for (t = 0; t < NTIM; t = t + 1) begin : gTim
      // Address decode for this timer
      // Second timer's words and control C sit one offset step above the first; mask and flags have their own addresses
      wire [7:0] tOfs = (t == 0) ? 8'h00 : `TTR_T3_OFS;
      wire [7:0] base = `TTR_T1_CNT_L + tOfs;
      wire [7:0] cbase = `TTR_T1_CTRL_C + tOfs;
      wire [7:0] maddr = (t == 0) ? `TTR_T1_MASK : `TTR_T3_MASK;
      wire [7:0] faddr = (t == 0) ? `TTR_T1_FLAGS : `TTR_T3_FLAGS;
      assign selCntL[t] = (ioAddr == base);
      assign selCntH[t] = (ioAddr == base + 8'h01);
      assign selCapL[t] = (ioAddr == base + 8'h02);
      assign selCapH[t] = (ioAddr == base + 8'h03);
      assign selCmpAL[t] = (ioAddr == base + 8'h04);
      assign selCmpAH[t] = (ioAddr == base + 8'h05);
      assign selCmpBL[t] = (ioAddr == base + 8'h06);
      assign selCmpBH[t] = (ioAddr == base + 8'h07);
      assign selMask[t] = (ioAddr == maddr);
      assign selFlags[t] = (ioAddr == faddr);
      assign selCtrlC[t] = (ioAddr == cbase);

      // Local views
      wire [15:0] cnt = counterValue[16*t+15:16*t];
      wire [15:0] cmpA = cmpA_reg[16*t+15:16*t];
      wire [15:0] cmpB = cmpB_reg[16*t+15:16*t];
      wire [3:0] mode = waveformModeBits[4*t+3:4*t];
      // Mode decode: source of TOP, and the non-PWM modes
      wire capIsTop = (mode == 4'd8) || (mode == 4'd10) ||
                      (mode == 4'd12) || (mode == 4'd14);
      wire ocrIsTop = (mode == 4'd9) || (mode == 4'd11) || (mode == 4'd15);
      wire nonPwm = (mode == 4'd0) || (mode == 4'd4) || (mode == 4'd12);
      // Capture word or compare A as TOP where selected, fixed TOP for the 8, 9 and 10-bit modes, MAX otherwise
      wire [15:0] top = capIsTop ? cap_reg[16*t+15:16*t] :
                        ocrIsTop ? cmpA :
                        (mode[1:0] == 2'd1) ? 16'h00FF :
                        (mode[1:0] == 2'd2) ? 16'h01FF :
                        (mode[1:0] == 2'd3) ? 16'h03FF : `TTR_MAX_WORD;
      wire tick = timerTick[t];
      // Equality evaluated at all times; flagged on the following tick
      wire eqA = (cnt == cmpA);
      wire eqB = (cnt == cmpB);
      wire hitA = tick & eqA & ~block_reg[t];
      wire hitB = tick & eqB & ~block_reg[t];
      // Overflow point depends on mode family
      // Normal and clear-on-compare modes at MAX, phase modes at BOTTOM,
      // fast modes at TOP
      wire atTop = (cnt == top);
      wire atBot = (cnt == `TTR_RST_WORD);
      wire ovfEv = tick & ((mode == 4'd0 || mode == 4'd4 || mode == 4'd12) ?
                   (cnt == `TTR_MAX_WORD) :
                   (mode[3] & ~mode[1] & ~mode[2]) ? atBot :
                   (mode[2]) ? atTop : atBot);
      // Capture source: pin event unless capture register is TOP
      // The pin is cut off while the capture word serves as TOP
      wire capFlagEv = capIsTop ? (tick & atTop) : captureEvent[t];
      wire capLoad = captureEvent[t] & ~capIsTop;
      // Write strobe shared by every register of this timer
      wire wr = ioWe;
      wire [3:0] setv = {capFlagEv, 1'b0, 1'b0, 1'b0} |
                        {1'b0, hitB, hitA, ovfEv};
      // Only ones in the written byte clear flags
      wire [3:0] w1c = (wr & selFlags[t]) ?
          {ioWdata[`TTR_BIT_CAP], ioWdata[`TTR_BIT_MB],
           ioWdata[`TTR_BIT_MA], ioWdata[`TTR_BIT_OVF]} : 4'b0000;
      wire [3:0] clr = w1c | vectorAck[4*t+3:4*t];
      wire [3:0] en = {mask_reg[8*t+`TTR_BIT_CAP], mask_reg[8*t+`TTR_BIT_MB],
                       mask_reg[8*t+`TTR_BIT_MA], mask_reg[8*t+`TTR_BIT_OVF]};

      // Per-timer registers
      // Reset clears every word, flag and pulse
      always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
          counterValue[16*t+15:16*t] <= `TTR_RST_WORD;
          cmpA_reg[16*t+15:16*t] <= `TTR_RST_WORD;
          cmpB_reg[16*t+15:16*t] <= `TTR_RST_WORD;
          cap_reg[16*t+15:16*t] <= `TTR_RST_WORD;
          mask_reg[8*t+7:8*t] <= `TTR_RST_BYTE;
          flag_reg[4*t+3:4*t] <= 4'h0;
          block_reg[t] <= 1'b0;
          counterWritten[t] <= 1'b0;
          irqRequest[4*t+3:4*t] <= 4'h0;
          matchPulse[2*t+1:2*t] <= 2'b00;
          forcePulse[2*t+1:2*t] <= 2'b00;
        end else begin
          // Counter: CPU write wins over counting
          counterWritten[t] <= wr & selCntL[t];
          if (wr & selCntL[t]) begin
            counterValue[16*t+15:16*t] <= {tempHigh_reg, ioWdata};
          end else if (tick) begin
            counterValue[16*t+15:16*t] <= counterNext[16*t+15:16*t];
          end
          // Blocking armed by a write, consumed by the next tick
          if (wr & selCntL[t]) begin
            block_reg[t] <= 1'b1;
          end else if (tick) begin
            block_reg[t] <= 1'b0;
          end
          // Compare words commit on the low-byte write
          if (wr & selCmpAL[t]) begin
            cmpA_reg[16*t+15:16*t] <= {tempHigh_reg, ioWdata};
          end
          if (wr & selCmpBL[t]) begin
            cmpB_reg[16*t+15:16*t] <= {tempHigh_reg, ioWdata};
          end
          // Capture word: hardware load wins over a CPU write; no load while it serves as TOP
          if (capLoad) begin
            cap_reg[16*t+15:16*t] <= cnt;
          end else if (wr & selCapL[t]) begin
            cap_reg[16*t+15:16*t] <= {tempHigh_reg, ioWdata};
          end
          // Mask keeps only the defined enables
          if (wr & selMask[t]) begin
            mask_reg[8*t+7:8*t] <= ioWdata & `TTR_USED_MASK;
          end
          // Flags: a set in the same cycle as a clear wins
          // so an event that meets a clear is never lost
          flag_reg[4*t+3:4*t] <= (flag_reg[4*t+3:4*t] & ~clr) | setv;
          // Request trails the flag by one cycle
          irqRequest[4*t+3:4*t] <= flag_reg[4*t+3:4*t] & en &
                                   {4{globalIrqEnable}};
          // Match pulse for the waveform stage, in step with the flag
          matchPulse[2*t+1:2*t] <= {hitB, hitA};
          // Force strobes only in non-PWM modes, never touch flags
          forcePulse[2*t+1:2*t] <= (wr & selCtrlC[t] & nonPwm) ?
              {ioWdata[`TTR_BIT_FOCB], ioWdata[`TTR_BIT_FOCA]} : 2'b00;
        end
      end
    end
  endgenerate

  // ==========================================
  // Read mux and shared latch control
  // Only low-byte reads of counter and capture have a side effect;
  // unmapped addresses and idle cycles read zero
  integer i;
  always @* begin
    rdata_next = `TTR_RST_BYTE;
    tempHigh_next = tempHigh_reg;
    for (i = 0; i < NTIM; i = i + 1) begin
      // High-byte writes go to the latch
      if (ioWe & (selCntH[i] | selCapH[i] | selCmpAH[i] | selCmpBH[i])) begin
        tempHigh_next = ioWdata;
      end
      if (ioRe) begin
        if (selCntL[i]) begin
          rdata_next = counterValue[16*i+7 -: 8];
          tempHigh_next = counterValue[16*i+15 -: 8];
        end
        if (selCapL[i]) begin
          rdata_next = cap_reg[16*i+7 -: 8];
          tempHigh_next = cap_reg[16*i+15 -: 8];
        end
        if (selCmpAL[i]) begin
          rdata_next = cmpA_reg[16*i+7 -: 8];
        end
        if (selCmpBL[i]) begin
          rdata_next = cmpB_reg[16*i+7 -: 8];
        end
        // High reads of counter and capture return the latch
        if (selCntH[i] | selCapH[i]) begin
          rdata_next = tempHigh_reg;
        end
        if (selCmpAH[i]) begin
          rdata_next = cmpA_reg[16*i+15 -: 8];
        end
        if (selCmpBH[i]) begin
          rdata_next = cmpB_reg[16*i+15 -: 8];
        end
        if (selMask[i]) begin
          rdata_next = mask_reg[8*i+7 -: 8];
        end
        if (selFlags[i]) begin
          rdata_next = {2'b00, flag_reg[4*i+3], 2'b00, flag_reg[4*i+2 -: 3]};
        end
        // Control C reads zero: strobes only
        if (selCtrlC[i]) begin
          rdata_next = `TTR_RST_BYTE;
        end
      end
    end
  end

  // Latch and read data registers
  // Read data is valid the cycle after the read strobe
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      tempHigh_reg <= `TTR_RST_BYTE;
      ioRdata <= `TTR_RST_BYTE;
    end else begin
      tempHigh_reg <= tempHigh_next;
      ioRdata <= rdata_next;
    end
  end

  // NTIM defaults to two identical sets
  // Each set owns its words, mask and flags; only the latch is shared

endmodule

// >>> verification/ttr_regs_chk.sv
// Checker for the dual timer register block, watching timer 0, the requests of both timers and the bus.
// Assumes the block's address map and one-cycle bus strobes.
`timescale 1ns/1ps
module ttr_regs_chk #(parameter NTIM = 2) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Bus
  input wire [7:0] ioAddr,
  input wire [7:0] ioWdata,
  input wire ioWe,
  input wire ioRe,
  input wire [7:0] ioRdata,
  // Timer side
  input wire globalIrqEnable,
  input wire [4*NTIM-1:0] vectorAck,
  input wire [NTIM-1:0] timerTick,
  input wire [4*NTIM-1:0] waveformModeBits,
  input wire [4*NTIM-1:0] irqRequest,
  input wire [2*NTIM-1:0] matchPulse,
  input wire [2*NTIM-1:0] forcePulse,
  input wire [NTIM-1:0] counterWritten
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // ====================
  // Read-back of unused and strobe-only bits
  mask_rsvd_a: assert property (ioRe && ioAddr == 8'h6F |=> !(ioRdata & 8'hD8))
    else $error("mask unused bit read as one");
  flag_rsvd_a: assert property (ioRe && ioAddr == 8'h36 |=> !(ioRdata & 8'hD8))
    else $error("flag unused bit read as one");
  force_read_a: assert property (ioRe && ioAddr == 8'h82 |=> ioRdata[7:6] == 2'b00)
    else $error("force strobe read as one");
  // ====================
  // Requests, matches and strobes
  irq_gate_a: assert property (!globalIrqEnable |=> irqRequest == 8'h00)
    else $error("request without global enable");
  match_tick_a: assert property (matchPulse[0] |-> $past(timerTick[0]))
    else $error("match without preceding tick");
  write_block_a: assert property (ioWe && ioAddr == 8'h84 ##1 !timerTick[0] ##1 timerTick[0]
    |=> matchPulse[1:0] == 2'b00)
    else $error("match after counter write");
  force_mode_a: assert property (forcePulse[0] |-> $past(ioWe && ioAddr == 8'h82
    && ioWdata[7]) && $past(waveformModeBits[3:0]) inside {4'd0, 4'd4, 4'd12})
    else $error("force pulse without cause");
  cnt_write_a: assert property (ioWe && ioAddr == 8'h84 |=> counterWritten[0])
    else $error("counter write not seen");
  vector_clear_a: assert property (vectorAck[1] && !timerTick[0] |-> ##2 !irqRequest[1])
    else $error("request stays after vector entry");
endmodule

bind ttr_timer_regs ttr_regs_chk #(.NTIM(NTIM)) ttr_regs_chk_i (
  .clock(clock), .nrst(nrst), .ioAddr(ioAddr), .ioWdata(ioWdata), .ioWe(ioWe),
  .ioRe(ioRe), .ioRdata(ioRdata), .globalIrqEnable(globalIrqEnable),
  .vectorAck(vectorAck), .timerTick(timerTick), .waveformModeBits(waveformModeBits),
  .irqRequest(irqRequest), .matchPulse(matchPulse), .forcePulse(forcePulse),
  .counterWritten(counterWritten));

// >>> verification/ttr_cpu_model.sv
// CPU core model: byte and word accesses on the timer I/O bus.
// Assumes strobes are taken on the rising edge; it drives at the falling edge.
`timescale 1ns/1ps
module ttr_cpu_model (
  // Clock and read data
  input wire clock,
  input wire [7:0] ioRdata,
  // Bus strobes
  output reg [7:0] ioAddr = 8'h00,
  output reg [7:0] ioWdata = 8'h00,
  output reg ioWe = 1'b0,
  output reg ioRe = 1'b0
);
  // Byte write; released data shows the inverse
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clock);
      ioAddr = a;
      ioWdata = d;
      ioWe = 1'b1;
      @(negedge clock);
      ioWe = 1'b0;
      ioWdata = ~d;
    end
  endtask
  // Byte read, data taken one cycle after the strobe
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge clock);
      ioAddr = a;
      ioRe = 1'b1;
      @(negedge clock);
      d = ioRdata;
      ioRe = 1'b0;
    end
  endtask
  // Word access: high byte written first, low byte read first
  task wr16(input [7:0] a, input [15:0] w);
    begin
      wr(a + 8'h01, w[15:8]);
      wr(a, w[7:0]);
    end
  endtask
  task rd16(input [7:0] a, output [15:0] w);
    begin
      rd(a, w[7:0]);
      rd(a + 8'h01, w[15:8]);
    end
  endtask
endmodule

// >>> verification/ttr_timer_regs_tb_top.sv
// Self-checking bench for both timer register sets.
// Assumes the CPU model drives the bus; this module drives the timer hooks.
`timescale 1ns/1ps
module ttr_timer_regs_tb_top;
  // Clock, reset and timer hooks
  reg clock = 1'b0;
  reg nrst = 1'b0;
  reg globalIrqEnable = 1'b0;
  reg [7:0] vectorAck = 8'h00;
  reg [1:0] timerTick = 2'b00;
  reg [1:0] captureEvent = 2'b00;
  reg [31:0] counterNext = 32'h0000_0000;
  reg [7:0] waveformModeBits = 8'h00;
  // Bus and outputs
  wire [7:0] ioAddr, ioWdata, ioRdata, irqRequest;
  wire ioWe, ioRe;
  wire [3:0] matchPulse, forcePulse;
  wire [31:0] counterValue;
  wire [1:0] counterWritten;
  integer errorCnt = 0;
  integer nChecks = 0;
  integer t;
  reg [15:0] w;
  reg [7:0] o, fa, ma;
  always #5 clock = ~clock;
  ttr_cpu_model cpu (.clock(clock), .ioRdata(ioRdata), .ioAddr(ioAddr),
    .ioWdata(ioWdata), .ioWe(ioWe), .ioRe(ioRe));
  ttr_timer_regs #(.NTIM(2)) ttr_timer_regs_i (.clock(clock), .nrst(nrst),
    .ioAddr(ioAddr), .ioWdata(ioWdata), .ioWe(ioWe), .ioRe(ioRe), .ioRdata(ioRdata),
    .globalIrqEnable(globalIrqEnable), .vectorAck(vectorAck), .timerTick(timerTick),
    .captureEvent(captureEvent), .counterNext(counterNext),
    .waveformModeBits(waveformModeBits), .irqRequest(irqRequest),
    .matchPulse(matchPulse), .forcePulse(forcePulse), .counterValue(counterValue),
    .counterWritten(counterWritten));
  // ====================
  // Compare, read-compare, pulse and verdict helpers
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      nChecks = nChecks + 1;
      if (seen !== exp) begin
        errorCnt = errorCnt + 1;
        $display("unexpected %0s: expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task rc(input string nm, input [7:0] a, input [7:0] e);
    reg [7:0] d;
    begin
      cpu.rd(a, d);
      chk(nm, {8'h00, d}, {8'h00, e});
    end
  endtask
  task tick;
    begin
      @(negedge clock);
      timerTick[t] = 1'b1;
      @(negedge clock);
      timerTick[t] = 1'b0;
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", nChecks, errorCnt);
      if (errorCnt == 0 && nChecks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Hang guard
  initial begin
    #200000;
    errorCnt = errorCnt + 1;
    summarize;
  end
  // ====================
  // Same sequence on both timers
  initial begin
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    for (t = 0; t < 2; t = t + 1) begin
      o = t[0] ? 8'h10 : 8'h00;
      fa = t[0] ? 8'h38 : 8'h36;
      ma = t[0] ? 8'h71 : 8'h6F;
      rc("mask", ma, 8'h00);
      cpu.wr(ma, 8'hFF);
      rc("mask", ma, 8'h27);
      cpu.wr16(8'h88 + o, 16'h1234);
      rc("cmpa lo", 8'h88 + o, 8'h34);
      cpu.wr(8'h8B + o, 8'h56);
      cpu.wr(8'h88 + o, 8'h78);
      rc("shared hi", 8'h89 + o, 8'h56);
      cpu.wr16(8'h88 + o, 16'h1234);
      cpu.wr16(8'h84 + o, 16'hABCD);
      chk("cnt written", {15'h0000, counterWritten[t]}, 16'h0001);
      @(negedge clock);
      chk("counter", counterValue[16*t +: 16], 16'hABCD);
      cpu.rd16(8'h84 + o, w);
      chk("counter rd", w, 16'hABCD);
      counterNext[16*t +: 16] = 16'h1234;
      cpu.wr16(8'h84 + o, 16'h1234);
      tick;
      chk("blocked pulse", {14'h0000, matchPulse[2*t +: 2]}, 16'h0000);
      rc("blocked", fa, 8'h00);
      tick;
      chk("match pulse", {14'h0000, matchPulse[2*t +: 2]}, 16'h0001);
      rc("match", fa, 8'h02);
      counterNext[16*t +: 16] = 16'hBEEF;
      tick;
      globalIrqEnable = 1'b1;
      repeat (2) @(negedge clock);
      chk("irq", {15'h0000, irqRequest[4*t+1]}, 16'h0001);
      vectorAck[4*t+1] = 1'b1;
      @(negedge clock);
      vectorAck[4*t+1] = 1'b0;
      rc("vector", fa, 8'h00);
      globalIrqEnable = 1'b0;
      captureEvent[t] = 1'b1;
      @(negedge clock);
      captureEvent[t] = 1'b0;
      cpu.rd16(8'h86 + o, w);
      chk("capture", w, 16'hBEEF);
      rc("cap flag", fa, 8'h20);
      cpu.wr(fa, 8'h00);
      rc("zero keeps", fa, 8'h20);
      cpu.wr(fa, 8'h20);
      rc("one clears", fa, 8'h00);
      cpu.wr(8'h82 + o, 8'hC0);
      chk("force pulse", {14'h0000, forcePulse[2*t +: 2]}, 16'h0003);
      rc("force flag", fa, 8'h00);
      rc("force rd", 8'h82 + o, 8'h00);
      waveformModeBits[4*t +: 4] = 4'd8;
      cpu.wr(8'h82 + o, 8'hC0);
      chk("force pwm", {14'h0000, forcePulse[2*t +: 2]}, 16'h0000);
      waveformModeBits[4*t +: 4] = 4'd0;
      cpu.wr16(8'h84 + o, 16'hFFFF);
      tick;
      rc("overflow", fa, 8'h01);
      waveformModeBits[4*t +: 4] = 4'd12;
      cpu.wr16(8'h86 + o, 16'hBEEF);
      tick;
      rc("top flag", fa, 8'h21);
      cpu.wr(fa, 8'h21);
      waveformModeBits[4*t +: 4] = 4'd0;
    end
    summarize;
  end
endmodule
